// *** hw/dsac_defines.svh ***
// Constants for the dual step attenuator control block
`ifndef DSAC_DEFINES_SVH
`define DSAC_DEFINES_SVH
`define DSAC_FRAME_BITS   56
`define DSAC_CNT_W        6
`define DSAC_CODE_W       5
`define DSAC_DAC_W        8
`define DSAC_P1_DAC_LSB   0
`define DSAC_P1_PRE_LSB   8
`define DSAC_P2_DAC_LSB   28
`define DSAC_P2_PRE_LSB   36
`define DSAC_PRE_FIELDS   4
`define DSAC_CODE_ZERO    5'h00
`define DSAC_DAC_ZERO     8'h00
`define DSAC_FRAME_ZERO   56'h00_0000_0000_0000
`endif

// *** hw/dsac_pkg.sv ***
// Types shared by the dual step attenuator control block
`include "dsac_defines.svh"
package dsac_pkg;
   typedef logic [`DSAC_CODE_W-1:0] dsac_code_t;
   typedef struct packed {
      logic [`DSAC_DAC_W-1:0]  dac;
      dsac_code_t [3:0]        preset;
   } dsac_path_cfg_t;
   typedef enum logic [1:0] {
      DSAC_PRE1,
      DSAC_PRE2,
      DSAC_PRE3,
      DSAC_PRE4
   } dsac_pre_sel_t;
endpackage : dsac_pkg

// *** hw/dsac_sync.sv ***
// Two flip-flop synchroniser for a bus of pin inputs
module dsac_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_in,
   input  wire logic         resetn_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         meta_q <= '0;
         q_out  <= '0;
      end else begin
         meta_q <= d_in;
         q_out  <= meta_q;
      end
   end
endmodule : dsac_sync

// *** hw/dsac_top.sv ***
// Dual 5-bit step attenuator control: serial preset frame, preset select and parallel bus
`include "dsac_defines.svh"
module dsac_top
   import dsac_pkg::*;
(
   input  wire logic                   CLK_IN,
   input  wire logic                   RESETN_IN,
   input  wire logic                   SCLK_IN,
   input  wire logic                   CSN_IN,
   input  wire logic                   SDATA_IN,
   input  wire logic                   STEP_ATTEN_SOURCE_SELECT_IN,
   input  wire logic                   PATH1_PRESET_SELECT_LOW_IN,
   input  wire logic                   PATH1_PRESET_SELECT_HIGH_IN,
   input  wire logic                   PATH2_PRESET_SELECT_LOW_IN,
   input  wire logic                   PATH2_PRESET_SELECT_HIGH_IN,
   input  wire logic [`DSAC_CODE_W-1:0] PATH1_PARALLEL_STEP_CODE_IN,
   input  wire logic [`DSAC_CODE_W-1:0] PATH2_PARALLEL_STEP_CODE_IN,
   output logic      [`DSAC_CODE_W-1:0] PATH1_PARALLEL_STEP_CODE_OUT,
   output logic      [`DSAC_CODE_W-1:0] PATH2_PARALLEL_STEP_CODE_OUT,
   output logic                        PATH1_PARALLEL_STEP_CODE_OE_OUT,
   output logic                        PATH2_PARALLEL_STEP_CODE_OE_OUT,
   output logic      [`DSAC_CODE_W-1:0] PATH1_STAGE_ENABLE_OUT,
   output logic      [`DSAC_CODE_W-1:0] PATH2_STAGE_ENABLE_OUT,
   output logic      [`DSAC_DAC_W-1:0]  PATH1_DAC_CODE_OUT,
   output logic      [`DSAC_DAC_W-1:0]  PATH2_DAC_CODE_OUT
);
   localparam int SW = 8 + 2 * `DSAC_CODE_W;

   function automatic dsac_code_t pick_preset(input dsac_path_cfg_t cfg, input logic lo, input logic hi);
      dsac_pre_sel_t sel;
      sel = dsac_pre_sel_t'({hi, lo});
      unique case (sel)
         DSAC_PRE1: pick_preset = cfg.preset[0];
         DSAC_PRE2: pick_preset = cfg.preset[1];
         DSAC_PRE3: pick_preset = cfg.preset[2];
         DSAC_PRE4: pick_preset = cfg.preset[3];
      endcase
   endfunction : pick_preset

   // All pin inputs except clock and reset pass two flip-flops
   logic [SW-1:0] raw_w;
   logic [SW-1:0] sync_w;
   // Chip select passes inverted, so the synchroniser's zero reset is the idle level and fakes no frame end
   assign raw_w = {SCLK_IN, ~CSN_IN, SDATA_IN, STEP_ATTEN_SOURCE_SELECT_IN,
                   PATH1_PRESET_SELECT_LOW_IN, PATH1_PRESET_SELECT_HIGH_IN,
                   PATH2_PRESET_SELECT_LOW_IN, PATH2_PRESET_SELECT_HIGH_IN,
                   PATH1_PARALLEL_STEP_CODE_IN, PATH2_PARALLEL_STEP_CODE_IN};

   dsac_sync #(.W(SW)) u_sync (
      .clk_in    (CLK_IN),
      .resetn_in (RESETN_IN),
      .d_in      (raw_w),
      .q_out     (sync_w)
   );

   logic                    sclk_s, cs_s, sdata_s, src_s;
   logic                    p1_lo_s, p1_hi_s, p2_lo_s, p2_hi_s;
   logic [`DSAC_CODE_W-1:0] p1_par_s, p2_par_s;
   assign {sclk_s, cs_s, sdata_s, src_s, p1_lo_s, p1_hi_s, p2_lo_s, p2_hi_s, p1_par_s, p2_par_s} = sync_w;
   wire csn_s = !cs_s;

   logic                           sclk_q, csn_q;
   logic [`DSAC_FRAME_BITS-1:0]    shift_q, shift_d;
   logic [`DSAC_CNT_W-1:0]         cnt_q, cnt_d;
   logic                           over_q, over_d;
   logic [`DSAC_FRAME_BITS-1:0]    hold_q, hold_d;

   wire sclk_rise = sclk_s && !sclk_q;
   wire cs_rise   = csn_s && !csn_q;
   wire shifting  = !csn_s && sclk_rise;
   wire cnt_full  = (cnt_q == `DSAC_CNT_W'(`DSAC_FRAME_BITS));
   wire frame_ok  = cs_rise && cnt_full && !over_q;

   // MSB first: each bit enters at bit 0 and the first ends at bit 55
   assign shift_d = shifting ? {shift_q[`DSAC_FRAME_BITS-2:0], sdata_s} : shift_q;
   assign cnt_d   = csn_s ? '0 : (shifting && !cnt_full) ? cnt_q + 1'b1 : cnt_q;
   assign over_d  = csn_s ? 1'b0 : (over_q || (shifting && cnt_full));
   assign hold_d  = frame_ok ? shift_q : hold_q;

   always_ff @(posedge CLK_IN) begin
      if (!RESETN_IN) begin
         sclk_q  <= 1'b0;
         csn_q   <= 1'b1;
         shift_q <= `DSAC_FRAME_ZERO;
         cnt_q   <= '0;
         over_q  <= 1'b0;
         hold_q  <= `DSAC_FRAME_ZERO;
      end else begin
         sclk_q  <= sclk_s;
         csn_q   <= csn_s;
         shift_q <= shift_d;
         cnt_q   <= cnt_d;
         over_q  <= over_d;
         hold_q  <= hold_d;
      end
   end

   dsac_path_cfg_t cfg1_w, cfg2_w;
   assign cfg1_w.dac    = hold_q[`DSAC_P1_DAC_LSB +: `DSAC_DAC_W];
   assign cfg1_w.preset = hold_q[`DSAC_P1_PRE_LSB +: `DSAC_PRE_FIELDS*`DSAC_CODE_W];
   assign cfg2_w.dac    = hold_q[`DSAC_P2_DAC_LSB +: `DSAC_DAC_W];
   assign cfg2_w.preset = hold_q[`DSAC_P2_PRE_LSB +: `DSAC_PRE_FIELDS*`DSAC_CODE_W];

   dsac_code_t pre1_w, pre2_w, code1_w, code2_w;
   assign pre1_w  = pick_preset(cfg1_w, p1_lo_s, p1_hi_s);
   assign pre2_w  = pick_preset(cfg2_w, p2_lo_s, p2_hi_s);
   // The parallel pins are only read in parallel mode, so the echo never loops back
   assign code1_w = src_s ? pre1_w : p1_par_s;
   assign code2_w = src_s ? pre2_w : p2_par_s;

   always_ff @(posedge CLK_IN) begin
      if (!RESETN_IN) begin
         PATH1_STAGE_ENABLE_OUT          <= `DSAC_CODE_ZERO;
         PATH2_STAGE_ENABLE_OUT          <= `DSAC_CODE_ZERO;
         PATH1_PARALLEL_STEP_CODE_OUT    <= `DSAC_CODE_ZERO;
         PATH2_PARALLEL_STEP_CODE_OUT    <= `DSAC_CODE_ZERO;
         PATH1_PARALLEL_STEP_CODE_OE_OUT <= 1'b0;
         PATH2_PARALLEL_STEP_CODE_OE_OUT <= 1'b0;
         PATH1_DAC_CODE_OUT              <= `DSAC_DAC_ZERO;
         PATH2_DAC_CODE_OUT              <= `DSAC_DAC_ZERO;
      end else begin
         PATH1_STAGE_ENABLE_OUT          <= code1_w;
         PATH2_STAGE_ENABLE_OUT          <= code2_w;
         PATH1_PARALLEL_STEP_CODE_OUT    <= src_s ? pre1_w : `DSAC_CODE_ZERO;
         PATH2_PARALLEL_STEP_CODE_OUT    <= src_s ? pre2_w : `DSAC_CODE_ZERO;
         PATH1_PARALLEL_STEP_CODE_OE_OUT <= src_s;
         PATH2_PARALLEL_STEP_CODE_OE_OUT <= src_s;
         PATH1_DAC_CODE_OUT              <= cfg1_w.dac;
         PATH2_DAC_CODE_OUT              <= cfg2_w.dac;
      end
   end

   // Latch only on a chip select rise after exactly the full bit count
   frame_latch_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (cs_rise && cnt_full && !over_q) |=> (hold_q == $past(shift_q)))
      else $error("Frame not latched on chip select rise");

   frame_reject_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (cs_rise && (!cnt_full || over_q)) |=> $stable(hold_q))
      else $error("Malformed frame changed holding registers");

   hold_stable_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      !cs_rise |=> $stable(hold_q))
      else $error("Holding registers changed outside a frame end");

   echo_drive_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      src_s |=> (PATH1_PARALLEL_STEP_CODE_OE_OUT && PATH2_PARALLEL_STEP_CODE_OE_OUT
                 && PATH1_PARALLEL_STEP_CODE_OUT == PATH1_STAGE_ENABLE_OUT
                 && PATH2_PARALLEL_STEP_CODE_OUT == PATH2_STAGE_ENABLE_OUT))
      else $error("Serial mode code not echoed on parallel pins");

   par_mode_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      !src_s |=> (!PATH1_PARALLEL_STEP_CODE_OE_OUT && PATH1_STAGE_ENABLE_OUT == $past(p1_par_s)
                  && PATH2_STAGE_ENABLE_OUT == $past(p2_par_s)))
      else $error("Parallel mode code not applied");

   p1_preset_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (src_s && {p1_hi_s, p1_lo_s} == 2'b01) |=> PATH1_STAGE_ENABLE_OUT == $past(hold_q[17:13]))
      else $error("Path one select 10 did not apply preset two");

   p2_preset_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (src_s && {p2_hi_s, p2_lo_s} == 2'b10) |=> PATH2_STAGE_ENABLE_OUT == $past(hold_q[50:46]))
      else $error("Path two select 01 did not apply preset three");

   p1_fourth_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (src_s && p1_lo_s && p1_hi_s) |=> PATH1_STAGE_ENABLE_OUT == $past(hold_q[27:23]))
      else $error("Path one preset four field wrong");

   p2_first_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (src_s && !p2_lo_s && !p2_hi_s) |=> PATH2_STAGE_ENABLE_OUT == $past(hold_q[40:36]))
      else $error("Path two preset one field wrong");

   bit_count_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (shifting && !cnt_full) |=> (cnt_q == $past(cnt_q) + 1'b1 && shift_q[0] == $past(sdata_s)))
      else $error("Serial bit not counted or shifted");

   csn_clear_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      csn_s |=> (cnt_q == '0 && !over_q))
      else $error("Bit count not cleared while chip select is high");

   frame_over_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (shifting && cnt_full) |=> over_q)
      else $error("Extra serial bit not flagged");

   p1_first_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (src_s && !p1_lo_s && !p1_hi_s)
      |=> PATH1_STAGE_ENABLE_OUT == $past(hold_q[`DSAC_P1_PRE_LSB +: `DSAC_CODE_W]))
      else $error("Path one select 00 did not apply preset one");

   p1_third_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (src_s && !p1_lo_s && p1_hi_s)
      |=> PATH1_STAGE_ENABLE_OUT == $past(hold_q[`DSAC_P1_PRE_LSB + 2 * `DSAC_CODE_W +: `DSAC_CODE_W]))
      else $error("Path one select 01 did not apply preset three");

   p2_second_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (src_s && p2_lo_s && !p2_hi_s)
      |=> PATH2_STAGE_ENABLE_OUT == $past(hold_q[`DSAC_P2_PRE_LSB + `DSAC_CODE_W +: `DSAC_CODE_W]))
      else $error("Path two select 10 did not apply preset two");

   p2_fourth_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (src_s && p2_lo_s && p2_hi_s)
      |=> PATH2_STAGE_ENABLE_OUT == $past(hold_q[`DSAC_P2_PRE_LSB + 3 * `DSAC_CODE_W +: `DSAC_CODE_W]))
      else $error("Path two preset four field wrong");

   echo_off_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      !src_s |=> (PATH1_PARALLEL_STEP_CODE_OUT == `DSAC_CODE_ZERO
                  && PATH2_PARALLEL_STEP_CODE_OUT == `DSAC_CODE_ZERO && !PATH2_PARALLEL_STEP_CODE_OE_OUT))
      else $error("Parallel pins driven outside serial mode");

   dac_code_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      1'b1 |=> (PATH1_DAC_CODE_OUT == $past(hold_q[`DSAC_P1_DAC_LSB +: `DSAC_DAC_W])
                && PATH2_DAC_CODE_OUT == $past(hold_q[`DSAC_P2_DAC_LSB +: `DSAC_DAC_W])))
      else $error("Converter code not taken from its frame bits");
endmodule : dsac_top

// *** verification/dsac_host_model.sv ***
// Serial host model that shifts preset frames into the attenuator control block
module dsac_host_model (
   input  wire logic clk_in,
   output logic      sclk_out,
   output logic      csn_out,
   output logic      sdata_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // Lines start idle and stay defined from time zero
   initial begin
      sclk_out = 1'b0;
      csn_out = 1'b1;
      sdata_out = 1'b0;
   end
   // Sends n bits, top bit first; counts other than 56 make a malformed frame
   task automatic send_frame(input logic [55:0] f, input int n);
      logic b;
      b = 1'b0;
      csn_out <= 1'b0;
      repeat (4) @(posedge clk_in);
      for (int k = n - 1; k >= 0; k--) begin
         b = (k < 56) ? f[k] : 1'b1;
         sdata_out <= b;
         repeat (4) @(posedge clk_in);
         sclk_out <= 1'b1;
         repeat (4) @(posedge clk_in);
         sclk_out <= 1'b0;
      end
      repeat (4) @(posedge clk_in);
      csn_out <= 1'b1;
      sdata_out <= ~b;
   endtask : send_frame
endmodule : dsac_host_model

// *** verification/testbench.sv ***
// Self-checking bench for the dual step attenuator control block
module testbench
   import dsac_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [55:0] FRAME_A = {5'h11, 5'h0E, 5'h18, 5'h07, 8'h3C, 5'h13, 5'h0C, 5'h05, 5'h1A, 8'hA5};
   localparam logic [55:0] FRAME_B = ~FRAME_A;
   logic       clk, resetn, src_sel, sclk, csn, sdata, p1_oe, p2_oe;
   logic [3:0] pre_sel;
   dsac_code_t p1_drv, p2_drv, p1_pin, p2_pin, p1_echo, p2_echo, p1_stage, p2_stage;
   logic [7:0] p1_dac, p2_dac;
   int         bad_count = 0;
   int         n_checks = 0;
   // Pin level: the device wins while it drives, the bench lets go in serial mode
   assign p1_pin = p1_oe ? p1_echo : p1_drv;
   assign p2_pin = p2_oe ? p2_echo : p2_drv;
   always #4 clk = ~clk;
   dsac_host_model dsac_host_model_inst (.clk_in(clk), .sclk_out(sclk), .csn_out(csn), .sdata_out(sdata));
   dsac_top dsac_top_inst (
      .CLK_IN(clk), .RESETN_IN(resetn), .SCLK_IN(sclk), .CSN_IN(csn), .SDATA_IN(sdata),
      .STEP_ATTEN_SOURCE_SELECT_IN(src_sel),
      .PATH1_PRESET_SELECT_LOW_IN(pre_sel[0]), .PATH1_PRESET_SELECT_HIGH_IN(pre_sel[1]),
      .PATH2_PRESET_SELECT_LOW_IN(pre_sel[2]), .PATH2_PRESET_SELECT_HIGH_IN(pre_sel[3]),
      .PATH1_PARALLEL_STEP_CODE_IN(p1_pin), .PATH2_PARALLEL_STEP_CODE_IN(p2_pin),
      .PATH1_PARALLEL_STEP_CODE_OUT(p1_echo), .PATH2_PARALLEL_STEP_CODE_OUT(p2_echo),
      .PATH1_PARALLEL_STEP_CODE_OE_OUT(p1_oe), .PATH2_PARALLEL_STEP_CODE_OE_OUT(p2_oe),
      .PATH1_STAGE_ENABLE_OUT(p1_stage), .PATH2_STAGE_ENABLE_OUT(p2_stage),
      .PATH1_DAC_CODE_OUT(p1_dac), .PATH2_DAC_CODE_OUT(p2_dac));
   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask : step
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check
   task automatic close_out();
      $display("checks %0d, mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out
   // Presets read as zero before any frame
   task automatic t_reset_state();
      src_sel <= 1'b1;
      step(4);
      check("path1 stage", 8'h00, p1_stage);
      check("path2 stage", 8'h00, p2_stage);
      check("path1 dac", 8'h00, p1_dac);
      check("path1 oe", 8'h01, p1_oe);
      check("path2 oe", 8'h01, p2_oe);
   endtask : t_reset_state
   // Each parallel bit alone, the other path gets the complement
   task automatic t_parallel();
      src_sel <= 1'b0;
      // The device lets go of the pins three cycles later; drive them only after that
      step(4);
      for (int b = 0; b < 5; b++) begin
         p1_drv <= 5'h01 << b;
         p2_drv <= ~(5'h01 << b);
         step(4);
         check("path1 stage", 8'(5'h01 << b), p1_stage);
         check("path2 stage", 8'(5'h1F ^ (5'h01 << b)), p2_stage);
         check("path1 oe", 8'h00, p1_oe);
         check("path2 oe", 8'h00, p2_oe);
         check("path1 echo off", 8'h00, p1_echo);
         check("path2 echo off", 8'h00, p2_echo);
      end
   endtask : t_parallel
   // Every select code on both paths, with the two paths on different codes
   task automatic t_presets();
      src_sel <= 1'b1;
      dsac_host_model_inst.send_frame(FRAME_A, 56);
      step(8);
      check("path1 dac", FRAME_A[7:0], p1_dac);
      check("path2 dac", FRAME_A[35:28], p2_dac);
      for (int i = 0; i < 4; i++) begin
         pre_sel <= {2'(3 - i), 2'(i)};
         step(4);
         check("path1 stage", FRAME_A[8 + 5 * i +: 5], p1_stage);
         check("path1 echo", FRAME_A[8 + 5 * i +: 5], p1_pin);
         check("path2 stage", FRAME_A[51 - 5 * i +: 5], p2_stage);
         check("path2 echo", FRAME_A[51 - 5 * i +: 5], p2_pin);
      end
   endtask : t_presets
   // Short and long frames are dropped, a whole one is taken
   task automatic t_malformed();
      dsac_host_model_inst.send_frame(FRAME_B, 55);
      step(8);
      check("short frame", FRAME_A[23 +: 5], p1_stage);
      dsac_host_model_inst.send_frame(FRAME_B, 57);
      step(8);
      check("long frame", FRAME_A[23 +: 5], p1_stage);
      dsac_host_model_inst.send_frame(FRAME_B, 56);
      step(8);
      check("new frame p1", FRAME_B[23 +: 5], p1_stage);
      check("new frame p2", FRAME_B[36 +: 5], p2_stage);
   endtask : t_malformed
   // A reset in mid-run clears outputs and stored presets, and the link works again after it
   task automatic t_mid_reset();
      resetn <= 1'b0;
      step(6);
      check("reset path1 stage", 8'h00, p1_stage);
      check("reset path1 oe", 8'h00, p1_oe);
      check("reset path2 echo", 8'h00, p2_echo);
      check("reset path2 dac", 8'h00, p2_dac);
      resetn <= 1'b1;
      step(4);
      check("cleared path1 stage", 8'h00, p1_stage);
      check("cleared path2 stage", 8'h00, p2_stage);
      check("cleared path2 dac", 8'h00, p2_dac);
      check("cleared path2 oe", 8'h01, p2_oe);
      dsac_host_model_inst.send_frame(FRAME_A, 56);
      step(8);
      check("after reset p1", FRAME_A[23 +: 5], p1_stage);
      check("after reset p2", FRAME_A[36 +: 5], p2_stage);
      check("after reset dac2", FRAME_A[35:28], p2_dac);
   endtask : t_mid_reset
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      $display("unexpected run length: expected end, seen timeout");
      close_out();
   end
   initial begin
      clk = 1'b0;
      resetn = 1'b0;
      src_sel = 1'b0;
      pre_sel = 4'h0;
      p1_drv = 5'h00;
      p2_drv = 5'h00;
      step(6);
      resetn <= 1'b1;
      step(3);
      t_reset_state();
      t_parallel();
      t_presets();
      t_malformed();
      t_mid_reset();
      close_out();
   end
endmodule : testbench
